// file: hdl/pmp_timing_pkg.sv
// Contract
// [RULE1] acknowledge mode 00: ignore the acknowledge input, end on wait timing
// [RULE2] mode 10: hold access open until acknowledge, no time-out; 11 reserved
// [RULE3] mode 01: wait for acknowledge, give up after strobe field or 255 Tcy
// [RULE4] alternate master wait is the 3-bit field plus three cycles
// [RULE5] setup before strobe is the setup field plus one quarter Tcy
// [RULE6] write strobe width is strobe field plus one half Tcy
// [RULE7] read strobe width is strobe field plus three quarters Tcy
// [RULE8] write hold is hold field plus one quarter Tcy
// [RULE9] read hold is exactly the hold field in whole Tcy
// [RULE10] each chip select has own fields; setup, strobe, hold in order
package pmp_timing_pkg;
   // time base
   localparam int TCY_NS = 40;
   localparam int CLK_NS = 10;
   localparam int QTR_CLKS = ((TCY_NS / 4) + CLK_NS - 1) / CLK_NS;
   localparam int QTR_PER_TCY = 4;
   localparam int TMO_DEFAULT_TCY = 255;
   localparam int ALTWAIT_BASE = 3;
   localparam int SETUP_EXTRA_QTR = 1;
   localparam int WR_STROBE_EXTRA_QTR = 2;
   localparam int RD_STROBE_EXTRA_QTR = 3;
   localparam int WR_HOLD_EXTRA_QTR = 1;
   // mode register fields
   localparam int ACKMODE_LSB = 14;
   localparam int ALTWAIT_LSB = 11;
   localparam int SETUP_LSB = 6;
   localparam int STROBE_LSB = 2;
   localparam int HOLD_LSB = 0;
   localparam logic [15:0] MODE_WMASK = 16'hf8ff;
   localparam logic [15:0] MODE_RESET = 16'h0000;
   // register map
   localparam logic [7:0] CS_MODE_BASE = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h20;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_TMO_BIT = 1;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      ACK_OFF = 2'b00,
      ACK_TMO = 2'b01,
      ACK_WAIT = 2'b10,
      ACK_RSVD = 2'b11
   } ack_mode_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SETUP = 3'b001,
      ST_STROBE = 3'b010,
      ST_HOLD = 3'b011,
      ST_DONE = 3'b100
   } phase_t;
endpackage

// file: hdl/sync2.sv
`timescale 1ns/1ps
module sync2 #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   // level in and out
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta;

   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i)
      begin
         meta <= '0;
         q_o <= '0;
      end
      else
      begin
         meta <= d_i;
         q_o <= meta;
      end
   end
endmodule

// file: hdl/cs_mode_reg.sv
`timescale 1ns/1ps
module cs_mode_reg (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   // write port
   input wire logic we_i,
   input wire logic [15:0] wdata_i,
   input wire logic [1:0] wstrb_i,
   // stored value
   output logic [15:0] value_o
);
   logic [15:0] lane;

   assign lane = {{8{wstrb_i[1]}}, {8{wstrb_i[0]}}}
      & pmp_timing_pkg::MODE_WMASK;

   // bits 10-8 never store, so they read as zero
   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i)
         value_o <= pmp_timing_pkg::MODE_RESET;
      else if (we_i)
         value_o <= (value_o & ~lane) | (wdata_i & lane);
   end
endmodule

// file: hdl/pmp_cs_timing.sv
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module pmp_cs_timing #(
   parameter int NCS = 2,
   parameter int AW = 8,
   parameter int PAW = 16,
   parameter int DW = 16
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   // axi4-lite write
   input wire logic [AW-1:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   // axi4-lite read
   input wire logic [AW-1:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   // access request
   input wire logic req_valid_i,
   output logic req_ready_o,
   input wire logic req_write_i,
   input wire logic req_alt_i,
   input wire logic [$clog2(NCS)-1:0] req_cs_i,
   input wire logic [PAW-1:0] req_addr_i,
   input wire logic [DW-1:0] req_wdata_i,
   // access answer
   output logic done_o,
   output logic timeout_o,
   output logic [DW-1:0] rdata_o,
   // parallel pins
   output logic [NCS-1:0] cs_n_o,
   output logic [PAW-1:0] addr_o,
   output logic rd_strobe_o,
   output logic wr_strobe_o,
   output logic [DW-1:0] data_o,
   output logic data_oe_o,
   input wire logic [DW-1:0] data_i,
   input wire logic [NCS-1:0] external_acknowledge_input_i
);
   localparam int CSW = $clog2(NCS);

   logic [15:0] mode_reg [NCS];
   logic [NCS-1:0] mode_we;
   logic [NCS-1:0] ack_s;
   logic [DW-1:0] data_s;
   logic aw_have, w_have, do_write;
   logic [AW-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic tmo_flag, tmo_event, tmo_q, wr_status;
   logic [31:0] rd_word;
   logic rd_hit;
   pmp_timing_pkg::phase_t state, next_state;
   logic [11:0] cnt, next_cnt;
   logic [CSW-1:0] cs_q;
   logic wr_q, alt_q, ack_sel, strobe_end;
   logic [15:0] mode_q, req_mode;
   logic [PAW-1:0] addr_q;
   logic [DW-1:0] wdata_q;
   pmp_timing_pkg::ack_mode_t ack_mode;
   logic [CSW-1:0] cs_cur;
   logic wr_cur;
   logic [2:0] f_am;
   logic [1:0] f_b, f_e;
   logic [3:0] f_m;

   // pins from outside pass two flops first
   sync2 #(.W(NCS)) u_ack_sync (
      .clk_sys_i(clk_sys_i),
      .rstn_i(rstn_i),
      .d_i(external_acknowledge_input_i),
      .q_o(ack_s)
   );
   sync2 #(.W(DW)) u_data_sync (
      .clk_sys_i(clk_sys_i),
      .rstn_i(rstn_i),
      .d_i(data_i),
      .q_o(data_s)
   );

   // [RULE10] one mode copy per chip select
   for (genvar i = 0; i < NCS; i++)
   begin : g_cs
      assign mode_we[i] = do_write
         && aw_addr[AW-1:2] == (AW-2)'(i)
         && aw_addr < pmp_timing_pkg::STATUS_OFS;
      cs_mode_reg u_mode (
         .clk_sys_i(clk_sys_i),
         .rstn_i(rstn_i),
         .we_i(mode_we[i]),
         .wdata_i(w_data[15:0]),
         .wstrb_i(w_strb[1:0]),
         .value_o(mode_reg[i])
      );
   end

   // write channel: address and data taken in either order
   assign s_axi_awready_o = !aw_have && !s_axi_bvalid_o;
   assign s_axi_wready_o = !w_have && !s_axi_bvalid_o;
   assign do_write = aw_have && w_have && !s_axi_bvalid_o;
   assign wr_status = do_write
      && aw_addr == pmp_timing_pkg::STATUS_OFS;

   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i)
      begin
         aw_have <= 1'b0;
         w_have <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         w_strb <= '0;
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o <= pmp_timing_pkg::RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid_i && s_axi_awready_o)
         begin
            aw_have <= 1'b1;
            aw_addr <= s_axi_awaddr_i;
         end
         if (s_axi_wvalid_i && s_axi_wready_o)
         begin
            w_have <= 1'b1;
            w_data <= s_axi_wdata_i;
            w_strb <= s_axi_wstrb_i;
         end
         if (do_write)
         begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o <= (|mode_we || wr_status)
               ? pmp_timing_pkg::RESP_OKAY
               : pmp_timing_pkg::RESP_SLVERR;
         end
         else if (s_axi_bvalid_o && s_axi_bready_i)
            s_axi_bvalid_o <= 1'b0;
      end
   end

   // read channel: answer one cycle after the address is taken
   assign s_axi_arready_o = !s_axi_rvalid_o;

   always_comb
   begin
      rd_word = '0;
      rd_hit = 1'b0;
      if (s_axi_araddr_i == pmp_timing_pkg::STATUS_OFS)
      begin
         rd_hit = 1'b1;
         rd_word[pmp_timing_pkg::STAT_BUSY_BIT] = state != pmp_timing_pkg::ST_IDLE;
         rd_word[pmp_timing_pkg::STAT_TMO_BIT] = tmo_flag;
      end
      for (int i = 0; i < NCS; i++)
      begin
         if (s_axi_araddr_i == AW'(4 * i))
         begin
            rd_hit = 1'b1;
            rd_word[15:0] = mode_reg[i];
         end
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i)
      begin
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o <= '0;
         s_axi_rresp_o <= pmp_timing_pkg::RESP_OKAY;
      end
      else if (s_axi_arvalid_i && s_axi_arready_o)
      begin
         s_axi_rvalid_o <= 1'b1;
         s_axi_rdata_o <= rd_word;
         s_axi_rresp_o <= rd_hit ? pmp_timing_pkg::RESP_OKAY
            : pmp_timing_pkg::RESP_SLVERR;
      end
      else if (s_axi_rready_i)
         s_axi_rvalid_o <= 1'b0;
   end

   // sticky time-out flag, write one to clear; a new event wins
   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i)
         tmo_flag <= 1'b0;
      else if (tmo_event)
         tmo_flag <= 1'b1;
      else if (wr_status && w_strb[0]
         && w_data[pmp_timing_pkg::STAT_TMO_BIT])
         tmo_flag <= 1'b0;
   end

   // fields of the chip select latched at the start of the access
   assign ack_mode = pmp_timing_pkg::ack_mode_t'(
      mode_q[pmp_timing_pkg::ACKMODE_LSB +: 2]);
   assign f_am = mode_q[pmp_timing_pkg::ALTWAIT_LSB +: 3];
   assign f_b = mode_q[pmp_timing_pkg::SETUP_LSB +: 2];
   assign f_m = mode_q[pmp_timing_pkg::STROBE_LSB +: 4];
   assign f_e = mode_q[pmp_timing_pkg::HOLD_LSB +: 2];
   assign req_mode = mode_reg[req_cs_i];
   assign ack_sel = ack_s[cs_q];
   assign req_ready_o = state == pmp_timing_pkg::ST_IDLE;
   // first setup cycle is launched from idle, before the capture lands
   assign cs_cur = (state == pmp_timing_pkg::ST_IDLE) ? req_cs_i : cs_q;
   assign wr_cur = (state == pmp_timing_pkg::ST_IDLE) ? req_write_i : wr_q;

   function automatic logic [11:0] qtr(input int n);
      qtr = 12'(n * pmp_timing_pkg::QTR_CLKS);
   endfunction

   // strobe phase length, or time-out window in mode 01
   function automatic logic [11:0] strobe_len(input logic [15:0] m,
      input logic wr, input logic alt);
      int fm;
      int am;
      fm = int'(m[pmp_timing_pkg::STROBE_LSB +: 4]);
      am = int'(m[pmp_timing_pkg::ALTWAIT_LSB +: 3]);
      if (alt)
         strobe_len = 12'(am + pmp_timing_pkg::ALTWAIT_BASE);
      else if (m[pmp_timing_pkg::ACKMODE_LSB +: 2]
         == pmp_timing_pkg::ACK_TMO)
         strobe_len = qtr(pmp_timing_pkg::QTR_PER_TCY * ((fm == 0)
            ? pmp_timing_pkg::TMO_DEFAULT_TCY : fm));
      else if (wr)
         strobe_len = qtr(pmp_timing_pkg::QTR_PER_TCY * fm
            + pmp_timing_pkg::WR_STROBE_EXTRA_QTR);
      else
         strobe_len = qtr(pmp_timing_pkg::QTR_PER_TCY * fm
            + pmp_timing_pkg::RD_STROBE_EXTRA_QTR);
   endfunction

   // ending condition of the strobe phase
   always_comb
   begin
      strobe_end = cnt == '0;
      tmo_event = 1'b0;
      if (!alt_q)
      begin
         case (ack_mode)
            // [RULE2] wait on acknowledge without limit
            pmp_timing_pkg::ACK_WAIT:
               strobe_end = ack_sel;
            // [RULE3] acknowledge or time-out
            pmp_timing_pkg::ACK_TMO:
            begin
               strobe_end = ack_sel || cnt == '0;
               tmo_event = state == pmp_timing_pkg::ST_STROBE
                  && !ack_sel && cnt == '0;
            end
            // [RULE1] acknowledge ignored, reserved acts alike
            default:
               strobe_end = cnt == '0;
         endcase
      end
   end

   // [RULE10] setup, strobe, hold in order
   always_comb
   begin
      next_state = state;
      next_cnt = (cnt == '0) ? cnt : cnt - 12'h001;
      case (state)
         pmp_timing_pkg::ST_IDLE:
            if (req_valid_i)
            begin
               next_state = pmp_timing_pkg::ST_SETUP;
               // [RULE5] setup field plus a quarter
               next_cnt = qtr(pmp_timing_pkg::QTR_PER_TCY
                  * int'(req_mode[pmp_timing_pkg::SETUP_LSB +: 2])
                  + pmp_timing_pkg::SETUP_EXTRA_QTR) - 12'h001;
            end
         pmp_timing_pkg::ST_SETUP:
            if (cnt == '0)
            begin
               next_state = pmp_timing_pkg::ST_STROBE;
               // [RULE6] [RULE7] [RULE4] strobe or alternate wait
               next_cnt = strobe_len(mode_q, wr_q, alt_q) - 12'h001;
            end
         pmp_timing_pkg::ST_STROBE:
            if (strobe_end)
            begin
               // [RULE9] read hold of zero skips the phase
               if (!wr_q && f_e == 2'h0)
                  next_state = pmp_timing_pkg::ST_DONE;
               else
                  next_state = pmp_timing_pkg::ST_HOLD;
               // [RULE8] [RULE9] hold length by direction
               next_cnt = wr_q
                  ? qtr(pmp_timing_pkg::QTR_PER_TCY * int'(f_e)
                     + pmp_timing_pkg::WR_HOLD_EXTRA_QTR) - 12'h001
                  : qtr(pmp_timing_pkg::QTR_PER_TCY * int'(f_e))
                     - 12'h001;
            end
         pmp_timing_pkg::ST_HOLD:
            if (cnt == '0)
               next_state = pmp_timing_pkg::ST_DONE;
         pmp_timing_pkg::ST_DONE:
            next_state = pmp_timing_pkg::ST_IDLE;
         default:
            next_state = pmp_timing_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i)
      begin
         state <= pmp_timing_pkg::ST_IDLE;
         cnt <= '0;
      end
      else
      begin
         state <= next_state;
         cnt <= next_cnt;
      end
   end

   // request captured once; later mode writes wait for the next access
   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i)
      begin
         cs_q <= '0;
         wr_q <= 1'b0;
         alt_q <= 1'b0;
         mode_q <= pmp_timing_pkg::MODE_RESET;
         addr_q <= '0;
         wdata_q <= '0;
      end
      else if (req_valid_i && req_ready_o)
      begin
         cs_q <= req_cs_i;
         wr_q <= req_write_i;
         alt_q <= req_alt_i;
         mode_q <= req_mode;
         addr_q <= req_addr_i;
         wdata_q <= req_wdata_i;
      end
   end

   // answer: data sampled at strobe end, seen two cycles late at the pin
   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i)
      begin
         rdata_o <= '0;
         tmo_q <= 1'b0;
         done_o <= 1'b0;
         timeout_o <= 1'b0;
      end
      else
      begin
         if (state == pmp_timing_pkg::ST_STROBE && strobe_end)
         begin
            tmo_q <= tmo_event;
            if (!wr_q)
               rdata_o <= data_s;
         end
         done_o <= next_state == pmp_timing_pkg::ST_DONE;
         // a flag left from an earlier access must not leak into this one
         timeout_o <= next_state == pmp_timing_pkg::ST_DONE
            && ((state == pmp_timing_pkg::ST_STROBE) ? tmo_event : tmo_q);
      end
   end

   // select, strobe and enable pins registered from the next phase so they switch with it; address and data load one cycle into setup
   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i)
      begin
         cs_n_o <= '1;
         addr_o <= '0;
         rd_strobe_o <= 1'b0;
         wr_strobe_o <= 1'b0;
         data_o <= '0;
         data_oe_o <= 1'b0;
      end
      else
      begin
         cs_n_o <= '1;
         rd_strobe_o <= next_state == pmp_timing_pkg::ST_STROBE && !wr_q;
         wr_strobe_o <= next_state == pmp_timing_pkg::ST_STROBE && wr_q;
         data_oe_o <= wr_cur && next_state != pmp_timing_pkg::ST_IDLE
            && next_state != pmp_timing_pkg::ST_DONE;
         if (next_state != pmp_timing_pkg::ST_IDLE
            && next_state != pmp_timing_pkg::ST_DONE)
            cs_n_o[cs_cur] <= 1'b0;
         if (state == pmp_timing_pkg::ST_SETUP)
         begin
            addr_o <= addr_q;
            data_o <= wdata_q;
         end
      end
   end

   // helper: cycles spent so far in the current phase
   logic [11:0] ph_len;
   logic leaving;
   assign leaving = next_state != state;
   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i || leaving)
         ph_len <= '0;
      else
         ph_len <= ph_len + 12'h001;
   end

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);

   chk_setup_len: assert property ( // [RULE5]
      state == pmp_timing_pkg::ST_SETUP && leaving
      |-> int'(ph_len) + 1 == (4 * int'(f_b) + 1) * pmp_timing_pkg::QTR_CLKS)
      else $error("setup length wrong");
   chk_wr_strobe: assert property ( // [RULE6]
      state == pmp_timing_pkg::ST_STROBE && leaving && wr_q && !alt_q
      && (ack_mode == pmp_timing_pkg::ACK_OFF
      || ack_mode == pmp_timing_pkg::ACK_RSVD)
      |-> int'(ph_len) + 1 == (4 * int'(f_m) + 2) * pmp_timing_pkg::QTR_CLKS)
      else $error("write strobe length wrong");
   chk_rd_strobe: assert property ( // [RULE7]
      state == pmp_timing_pkg::ST_STROBE && leaving && !wr_q && !alt_q
      && ack_mode == pmp_timing_pkg::ACK_OFF
      |-> int'(ph_len) + 1 == (4 * int'(f_m) + 3) * pmp_timing_pkg::QTR_CLKS)
      else $error("read strobe length wrong");
   chk_wr_hold: assert property ( // [RULE8]
      state == pmp_timing_pkg::ST_HOLD && leaving && wr_q
      |-> int'(ph_len) + 1 == (4 * int'(f_e) + 1) * pmp_timing_pkg::QTR_CLKS)
      else $error("write hold length wrong");
   chk_rd_hold: assert property ( // [RULE9]
      state == pmp_timing_pkg::ST_STROBE && leaving && !wr_q
      |=> (f_e == 2'h0) == (state == pmp_timing_pkg::ST_DONE))
      else $error("read hold skip wrong");
   chk_ack_ignored: assert property ( // [RULE1]
      state == pmp_timing_pkg::ST_STROBE
      && ack_mode == pmp_timing_pkg::ACK_OFF
      && cnt != '0 |=> state == pmp_timing_pkg::ST_STROBE)
      else $error("acknowledge not ignored");
   chk_ack_wait: assert property ( // [RULE2]
      state == pmp_timing_pkg::ST_STROBE
      && ack_mode == pmp_timing_pkg::ACK_WAIT
      && !alt_q |-> ack_sel == leaving)
      else $error("acknowledge wait broken");
   chk_ack_timeout: assert property ( // [RULE3]
      tmo_event |-> int'(ph_len) + 1 == 4 * pmp_timing_pkg::QTR_CLKS
      * ((f_m == 4'h0) ? pmp_timing_pkg::TMO_DEFAULT_TCY : int'(f_m)))
      else $error("time-out length wrong");
   chk_alt_wait: assert property ( // [RULE4]
      state == pmp_timing_pkg::ST_STROBE && leaving && alt_q
      |-> int'(ph_len) + 1 == int'(f_am) + 3)
      else $error("alternate wait length wrong");
   chk_phase_order: assert property ( // [RULE10]
      state == pmp_timing_pkg::ST_SETUP && leaving
      |=> state == pmp_timing_pkg::ST_STROBE ##1 !cs_n_o[cs_q])
      else $error("phase order broken");

   cov_write: cover property (wr_q && state == pmp_timing_pkg::ST_HOLD);
   cov_read_ack: cover property (!wr_q && ack_sel
      && state == pmp_timing_pkg::ST_STROBE);
   cov_timeout: cover property (tmo_event);
endmodule

// file: dv/ext_device_model.sv
`timescale 1ns/1ps
module ext_device_model (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   // pins from the port
   input wire logic [1:0] cs_n_i,
   input wire logic [15:0] addr_i,
   input wire logic rd_strobe_i,
   input wire logic wr_strobe_i,
   input wire logic [15:0] data_i,
   input wire logic data_oe_i,
   // behaviour set by the bench
   input wire logic ack_en_i,
   input wire logic [11:0] ack_dly_i,
   input wire logic [15:0] rd_word_i,
   // pins back to the port
   output logic [15:0] data_o,
   output logic [1:0] ack_o,
   // last write seen
   output logic [15:0] wr_word_o,
   output logic [15:0] wr_addr_o
);
   logic [11:0] cnt;
   logic [15:0] last;
   logic sel;
   assign sel = !(cs_n_i[0] && cs_n_i[1]);
   // a released bus shows the inverse, so a stale copy never passes
   assign data_o = (sel && !data_oe_i) ? rd_word_i : ~last;
   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i)
         last <= '0;
      else if (sel && !data_oe_i)
         last <= rd_word_i;
   end
   // ack only on the selected line, held until the strobe ends
   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i || !(rd_strobe_i || wr_strobe_i))
      begin
         cnt <= '0;
         ack_o <= '0;
      end
      else
      begin
         cnt <= cnt + 12'h001;
         if (ack_en_i && cnt >= ack_dly_i)
            ack_o <= ~cs_n_i;
      end
   end
   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i)
      begin
         wr_word_o <= '0;
         wr_addr_o <= '0;
      end
      else if (wr_strobe_i && sel)
      begin
         wr_word_o <= data_i;
         wr_addr_o <= addr_i;
      end
   end
endmodule

// file: dv/parallel_port_chip_select_timing_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) \
   begin \
      checked++; \
      if ((g) !== (e)) \
      begin \
         error_cnt++; \
         $display("Error %s expected %0h seen %0h", nm, e, g); \
      end \
   end
module parallel_port_chip_select_timing_tb;
   logic clk = 1'b0, rstn = 1'b0;
   logic [7:0] aw_addr = '0, ar_addr = '0;
   logic aw_valid = 0, w_valid = 0, b_ready = 0, ar_valid = 0, r_ready = 0;
   logic [31:0] w_data = '0, r_data;
   logic [3:0] w_strb = '0;
   logic aw_ready, w_ready, b_valid, ar_ready, r_valid;
   logic [1:0] b_resp, r_resp, cs_n, ack, rsp;
   logic req_valid = 0, req_write = 0, req_alt = 0, req_cs = 0;
   logic [15:0] req_addr = '0, req_wdata = '0, rdata, addr, dout, din;
   logic req_ready, done, tmo, rd_stb, wr_stb, oe, ack_en = 0, to;
   logic [11:0] ack_dly = '0;
   logic [15:0] rd_word = '0, dev_word, dev_addr, wv;
   logic [31:0] rv;
   int error_cnt = 0, checked = 0, cycles = 0, su, st, ho;
   int t_acknowledge_mode_field[7] = '{0, 3, 2, 2, 1, 1, 1};
   int t_m[7] = '{2, 2, 2, 0, 3, 0, 3};
   int t_dly[7] = '{0, 0, 20, 1100, 4095, 4095, 2};
   int t_lo[7] = '{11, 11, 21, 1101, 12, 1020, 3};
   int t_hi[7] = '{11, 11, 26, 1106, 12, 1020, 8};
   int t_to[7] = '{0, 0, 0, 0, 1, 1, 0};
   always #5 clk = ~clk;
   pmp_cs_timing uut (.clk_sys_i(clk), .rstn_i(rstn),
      .s_axi_awaddr_i(aw_addr), .s_axi_awvalid_i(aw_valid),
      .s_axi_awready_o(aw_ready), .s_axi_wdata_i(w_data),
      .s_axi_wstrb_i(w_strb), .s_axi_wvalid_i(w_valid),
      .s_axi_wready_o(w_ready), .s_axi_bresp_o(b_resp),
      .s_axi_bvalid_o(b_valid), .s_axi_bready_i(b_ready),
      .s_axi_araddr_i(ar_addr), .s_axi_arvalid_i(ar_valid),
      .s_axi_arready_o(ar_ready), .s_axi_rdata_o(r_data),
      .s_axi_rresp_o(r_resp), .s_axi_rvalid_o(r_valid),
      .s_axi_rready_i(r_ready), .req_valid_i(req_valid),
      .req_ready_o(req_ready), .req_write_i(req_write),
      .req_alt_i(req_alt), .req_cs_i(req_cs), .req_addr_i(req_addr),
      .req_wdata_i(req_wdata), .done_o(done), .timeout_o(tmo),
      .rdata_o(rdata), .cs_n_o(cs_n), .addr_o(addr),
      .rd_strobe_o(rd_stb), .wr_strobe_o(wr_stb), .data_o(dout),
      .data_oe_o(oe), .data_i(din), .external_acknowledge_input_i(ack));
   ext_device_model dev (.clk_sys_i(clk), .rstn_i(rstn), .cs_n_i(cs_n),
      .addr_i(addr), .rd_strobe_i(rd_stb), .wr_strobe_i(wr_stb),
      .data_i(dout), .data_oe_i(oe), .ack_en_i(ack_en),
      .ack_dly_i(ack_dly), .rd_word_i(rd_word), .data_o(din),
      .ack_o(ack), .wr_word_o(dev_word), .wr_addr_o(dev_addr));
   task automatic conclude();
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // watchdog sized well above the longest wait of the run
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 12000)
      begin
         error_cnt++;
         $display("Error watchdog expected done seen hang");
         conclude();
      end
   end
   function automatic logic [31:0] cfg(int am, int aw, int b, int m, int e);
      return {16'h0, 2'(am), 3'(aw), 3'b000, 2'(b), 4'(m), 2'(e)};
   endfunction
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s, input logic [1:0] er);
      logic pa, pw, ta, tw;
      pa = 1;
      pw = 1;
      aw_addr <= a;
      w_data <= d;
      w_strb <= s;
      aw_valid <= 1'b1;
      w_valid <= 1'b1;
      while (pa || pw)
      begin
         @(negedge clk);
         ta = pa && aw_ready;
         tw = pw && w_ready;
         @(posedge clk);
         if (ta)
            aw_valid <= 1'b0;
         if (tw)
            w_valid <= 1'b0;
         pa = pa && !ta;
         pw = pw && !tw;
      end
      b_ready <= 1'b1;
      do
      begin
         @(negedge clk);
         ta = b_valid;
         rsp = b_resp;
         @(posedge clk);
      end
      while (!ta);
      b_ready <= 1'b0;
      `CHK("bresp", er, rsp)
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ed,
      input logic [1:0] er);
      logic t;
      ar_addr <= a;
      ar_valid <= 1'b1;
      do
      begin
         @(negedge clk);
         t = ar_ready;
         @(posedge clk);
      end
      while (!t);
      ar_valid <= 1'b0;
      r_ready <= 1'b1;
      do
      begin
         @(negedge clk);
         t = r_valid;
         rv = r_data;
         rsp = r_resp;
         @(posedge clk);
      end
      while (!t);
      r_ready <= 1'b0;
      `CHK("rdata", ed, rv)
      `CHK("rresp", er, rsp)
   endtask
   // one access, counting setup, strobe and hold cycles at the pins
   task automatic access(input logic cs, input logic w, input logic alt);
      logic t;
      su = 0;
      st = 0;
      ho = 0;
      req_cs <= cs;
      req_write <= w;
      req_alt <= alt;
      req_addr <= ~wv;
      req_wdata <= wv;
      req_valid <= 1'b1;
      do
      begin
         @(negedge clk);
         t = req_ready;
         @(posedge clk);
      end
      while (!t);
      req_valid <= 1'b0;
      t = 0;
      while (!t)
      begin
         @(negedge clk);
         t = done;
         to = tmo;
         if (!t && (rd_stb || wr_stb))
            st++;
         else if (!t && !cs_n[cs] && st == 0)
            su++;
         else if (!t && !cs_n[cs])
            ho++;
         @(posedge clk);
      end
   endtask
   task automatic run(input logic cs, input logic w, int esu, int est,
      int eho);
      access(cs, w, 1'b0);
      `CHK("setup cycles", esu, su)
      `CHK("strobe cycles", est, st)
      `CHK("hold cycles", eho, ho)
      `CHK("timeout", 1'b0, to)
   endtask
   initial
   begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      `CHK("idle selects", 2'b11, cs_n)
      rd(8'h00, 32'h0, pmp_timing_pkg::RESP_OKAY);
      wr(8'h04, 32'hffffffff, 4'hf, pmp_timing_pkg::RESP_OKAY);
      rd(8'h04, 32'(pmp_timing_pkg::MODE_WMASK), 2'h0);
      rd(8'h00, 32'h0, pmp_timing_pkg::RESP_OKAY);
      wr(8'h04, 32'h0, 4'h1, pmp_timing_pkg::RESP_OKAY);
      rd(8'h04, 32'h0000f800, pmp_timing_pkg::RESP_OKAY);
      rd(8'h10, 32'h0, pmp_timing_pkg::RESP_SLVERR);
      wr(8'h10, 32'h1, 4'hf, pmp_timing_pkg::RESP_SLVERR);
      $display("test registers done");
      for (int k = 0; k < 4; k++)
      begin
         wr(8'h00, cfg(0, 0, k, 5 * k, k), 4'h3, 2'h0);
         wr(8'h04, cfg(0, 0, 3 - k, 15 - 5 * k, 3 - k), 4'h3, 2'h0);
         wv = 16'ha5c0 + 16'(k);
         rd_word <= 16'h5a00 + 16'(k);
         run(1'b0, 1'b1, 4 * k + 1, 20 * k + 2,
            4 * k + 1);
         `CHK("write word", wv, dev_word)
         `CHK("write addr", ~wv, dev_addr)
         run(1'b1, 1'b0, 13 - 4 * k, 63 - 20 * k,
            12 - 4 * k);
         `CHK("read word", rd_word, rdata)
      end
      $display("test timing sweep done");
      for (int i = 0; i < 7; i++)
      begin
         wr(8'h04, cfg(t_acknowledge_mode_field[i], 0, 0, t_m[i], 0), 4'h3, 2'h0);
         ack_en <= (t_dly[i] != 4095);
         ack_dly <= 12'(t_dly[i]);
         access(1'b1, 1'b0, 1'b0);
         `CHK("strobe range", 1'b1,
            st >= t_lo[i] && st <= t_hi[i])
         `CHK("timeout flag", 1'(t_to[i]), to)
      end
      rd(pmp_timing_pkg::STATUS_OFS, 32'h2, 2'h0);
      wr(pmp_timing_pkg::STATUS_OFS, 32'h2, 4'hf, 2'h0);
      rd(pmp_timing_pkg::STATUS_OFS, 32'h0, 2'h0);
      $display("test acknowledge done");
      // waiting for ack with none coming: an alt access must not hang
      ack_en <= 1'b0;
      for (int a = 0; a < 8; a += 7)
      begin
         wr(8'h00, cfg(2, a, 0, 0, 0), 4'h3, 2'h0);
         access(1'b0, 1'b1, 1'b1);
         `CHK("alt wait cycles", a + 3, st)
      end
      $display("test alternate master done");
      conclude();
   end
endmodule
